// ---- fsrsc_flash_model.sv ----
// Behavioural flash device that faces the host controller pins.
`default_nettype none
module fsrsc_flash_model
   import fsrsc_pkg::*;
(
   input  wire logic              chipSelN,
   input  wire logic              writeEnN,
   input  wire logic              outputEnN,
   input  wire logic              resetN,
   input  wire logic [ADDR_W-1:0] flashAddr,
   input  wire logic [7:0]        dataOut,
   input  wire logic              dataOe,
   output logic [7:0]             dataIn,
   output logic                   ready_busy_out,
   output logic [ADDR_W-1:0]      lastAddr,
   output logic [ADDR_W-1:0]      rdAddr,
   output logic [7:0]             lastData,
   output int                     lowNs
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] START_CMD = 8'h29; // Arbitrary start byte.
   localparam logic [7:0] PROT_BLK  = 8'h50;
   logic [7:0] rd;
   time        lowAt;
   initial begin
      ready_busy_out = 1'b1;
      lowAt = 0;
   end
   // Commands latch on the rising write strobe, as on the real part.
   // suspend, resume delays
   always @(posedge writeEnN) begin
      if (!chipSelN && !dataOe) begin
         lastAddr = flashAddr;
         lastData = dataOut;
         if (dataOut == CMD_SUSPEND)
            #1000 ready_busy_out = 1'b1;
         else if (dataOut == CMD_RESUME || dataOut == START_CMD)
            #60 ready_busy_out = 1'b0;
      end
   end
   // Read address is kept so the bench can see where status was polled.
   always @(negedge outputEnN) if (!chipSelN) rdAddr = flashAddr;
   // width measured, operation abandoned at once
   always @(negedge resetN) begin
      lowAt = $time;
      ready_busy_out = 1'b1;
   end
   always @(posedge resetN) lowNs = int'($time - lowAt);
   // protect mark only for the ID select of a protected block
   always_comb begin
      if ((flashAddr & ID_SEL_MASK) == ID_PROT_SEL)
         rd = (flashAddr[19:12] == PROT_BLK) ? PROT_MARK : 8'h00;
      else
         rd = {ready_busy_out, 7'h00};
   end
   // A released bus shows the inverse, so a stale sample cannot pass.
   assign dataIn = (!chipSelN && !outputEnN) ? rd : ~rd;
endmodule
`default_nettype wire

// ---- fsrsc_host.sv ----
// Host controller driving the flash pins for commands, reset and polling.
`default_nettype none
module fsrsc_host
   import fsrsc_pkg::*;
(
   input  wire  logic              clk,
   input  wire  logic              reset,
   input  wire  logic              reqValid,
   output logic                    reqReady,
   input  wire  fsrsc_op_type      reqOp,
   input  wire  logic [ADDR_W-1:0] reqAddr,
   input  wire  logic [7:0]        reqData,
   input  wire  logic              reqErasing,
   output logic                    respValid,
   output logic [7:0]              respData,
   output logic                    respFlag,
   output logic                    chipSelN,
   output logic                    writeEnN,
   output logic                    outputEnN,
   output logic                    resetN,
   output logic [ADDR_W-1:0]       flashAddr,
   output logic [7:0]              dataOut,
   output logic                    dataOe,
   input  wire  logic [7:0]        dataIn,
   input  wire  logic              ready_busy_out
);
   fsrsc_state_type        stateReg;
   fsrsc_op_type           opReg;
   logic [CNT_W-1:0]       cntReg;
   logic [CNT_W-1:0]       waitCyc;
   logic                   busyLateReg;
   logic                   suspendedReg;
   logic [ADDR_W-1:0]      blockReg;

   assign reqReady = (stateReg == FS_IDLE);

   // Wait after suspend or resume is sized by the device's worst latency.
   always_comb begin
      waitCyc = CNT_W'(RESUME_CYC);
      if (opReg == OP_SUSPEND && !reqErasing)
         waitCyc = CNT_W'(SUSP_PGM_CYC);
      else if (opReg == OP_SUSPEND)
         waitCyc = CNT_W'(SUSP_ERS_CYC);
   end

   // Main sequencer; every command pulse lasts a fixed write window.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         stateReg <= FS_IDLE;
         opReg <= OP_WRITE;
         cntReg <= '0;
      end else begin
         unique case (stateReg)
            FS_IDLE: begin
               cntReg <= '0;
               if (reqValid) begin
                  opReg <= reqOp;
                  if (reqOp == OP_RESET)
                     stateReg <= FS_RESET;
                  else if (reqOp == OP_READ || reqOp == OP_PROTCHK ||
                           reqOp == OP_POLL)
                     stateReg <= FS_READ;
                  else
                     stateReg <= FS_WRITE;
               end
            end
            FS_WRITE: begin
               cntReg <= cntReg + 1'b1;
               if (cntReg == CNT_W'(WRITE_CYC - 1)) begin
                  cntReg <= '0;
                  stateReg <= (opReg == OP_SUSPEND || opReg == OP_RESUME)
                              ? FS_WAIT : FS_IDLE;
               end
            end
            FS_READ: begin
               cntReg <= cntReg + 1'b1;
               if (cntReg == CNT_W'(WRITE_CYC - 1))
                  stateReg <= FS_IDLE;
            end
            FS_WAIT: begin
               cntReg <= cntReg + 1'b1;
               if (cntReg == waitCyc - 1'b1)
                  stateReg <= FS_IDLE;
            end
            FS_RESET: begin
               cntReg <= cntReg + 1'b1;
               if (cntReg == CNT_W'(RESET_LOW_CYC - 1)) begin
                  cntReg <= '0;
                  stateReg <= FS_RECOV;
               end
            end
            FS_RECOV: begin
               cntReg <= cntReg + 1'b1;
               if (cntReg == CNT_W'(READY_CYC - 1))
                  stateReg <= FS_IDLE;
            end
            default: stateReg <= FS_IDLE;
         endcase
      end
   end

   // Suspend tracking and suspended block, used for poll address choice.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         suspendedReg <= 1'b0;
         blockReg <= '0;
      end else if (stateReg == FS_IDLE && reqValid) begin
         if (reqOp == OP_SUSPEND && reqErasing) begin
            suspendedReg <= 1'b1;
            blockReg <= reqAddr & BLOCK_MASK;
         end else if (reqOp == OP_RESUME || reqOp == OP_RESET)
            suspendedReg <= 1'b0;
      end
   end

   // Pin drive: write strobe low in the middle of the window, read strobe low to its end, address held.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         chipSelN <= 1'b1;
         writeEnN <= 1'b1;
         outputEnN <= 1'b1;
         resetN <= 1'b1;
         flashAddr <= '0;
         dataOut <= '0;
         dataOe <= 1'b1;
      end else begin
         resetN <= !(stateReg == FS_IDLE && reqValid && reqOp == OP_RESET)
                   && !(stateReg == FS_RESET &&
                        cntReg != CNT_W'(RESET_LOW_CYC - 1));
         if (stateReg == FS_IDLE && reqValid) begin
            flashAddr <= reqAddr;
            if (reqOp == OP_POLL && suspendedReg &&
                (reqAddr & BLOCK_MASK) == blockReg)
               // Step to the start of the next block, outside the suspended one.
               flashAddr <= (blockReg | ~BLOCK_MASK) + ADDR_W'(1);
            if (reqOp == OP_PROTCHK)
               flashAddr <= (reqAddr & ~ID_SEL_MASK) | ID_PROT_SEL;
            dataOut <= (reqOp == OP_SUSPEND) ? CMD_SUSPEND :
                       (reqOp == OP_RESUME) ? CMD_RESUME : reqData;
            chipSelN <= (reqOp == OP_RESET);
            dataOe <= !(reqOp == OP_WRITE || reqOp == OP_SUSPEND ||
                        reqOp == OP_RESUME);
         end else if ((stateReg == FS_WRITE || stateReg == FS_READ) &&
                      cntReg == CNT_W'(WRITE_CYC - 1)) begin
            chipSelN <= 1'b1;
            dataOe <= 1'b1;
         end
         // The write strobe rises a cycle before chip select does, so the
         // device latches the command while it is still selected.
         writeEnN <= !(stateReg == FS_WRITE &&
                       cntReg < CNT_W'(WRITE_CYC - 2));
         outputEnN <= !(stateReg == FS_READ && cntReg != CNT_W'(WRITE_CYC-1));
      end
   end

   // Read capture; the protect flag compares against the marker value.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         respValid <= 1'b0;
         respData <= '0;
         respFlag <= 1'b0;
      end else begin
         respValid <= 1'b0;
         if (stateReg == FS_READ && cntReg == CNT_W'(WRITE_CYC - 1)) begin
            respValid <= 1'b1;
            respData <= dataIn;
            respFlag <= (opReg == OP_PROTCHK) ? (dataIn == PROT_MARK)
                                               : !ready_busy_out;
         end
      end
   end

   // Busy watch during write windows; a late busy is only logged, not fatal.
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         busyLateReg <= 1'b0;
      else if (stateReg == FS_WRITE)
         busyLateReg <= !ready_busy_out;
   end

   // multi-block erase entries are plain back to back writes.
   // host takes a new start as soon as it is idle; it does not wait for ready_busy_out.

   a_reset_width: assert property (@(posedge clk) disable iff (reset)
      $fell(resetN) |-> !resetN [*8] ##1 !resetN [*8] ##1 !resetN [*8])
      else $error("reset pulse too short");
   a_recov_ready: assert property (@(posedge clk) disable iff (reset)
      $rose(resetN) |-> stateReg == FS_RECOV [*8])
      else $error("request taken during reset recovery");
   a_protect_sel: assert property (@(posedge clk) disable iff (reset)
      (stateReg == FS_READ && opReg == OP_PROTCHK) |->
      (flashAddr & ID_SEL_MASK) == ID_PROT_SEL)
      else $error("protect verify address wrong");
   a_protect_flag: assert property (@(posedge clk) disable iff (reset)
      (respValid && opReg == OP_PROTCHK) |-> respFlag == (respData == PROT_MARK))
      else $error("protect flag mismatch");
   a_suspend_wait: assert property (@(posedge clk) disable iff (reset)
      (stateReg == FS_WRITE && opReg == OP_SUSPEND && !reqErasing &&
       cntReg == CNT_W'(WRITE_CYC - 1)) |-> ##1 stateReg == FS_WAIT [*8])
      else $error("suspend wait cut short");
   a_resume_wait: assert property (@(posedge clk) disable iff (reset)
      (stateReg == FS_WAIT && opReg == OP_RESUME) |-> ##[0:50] reqReady)
      else $error("resume wait too long");
   a_erase_wait: assert property (@(posedge clk) disable iff (reset)
      (stateReg == FS_WAIT && opReg == OP_SUSPEND) |-> ##[0:750] reqReady)
      else $error("erase suspend wait too long");
   a_poll_outside: assert property (@(posedge clk) disable iff (reset)
      (stateReg == FS_READ && opReg == OP_POLL && suspendedReg) |->
      (flashAddr & BLOCK_MASK) != blockReg)
      else $error("poll inside suspended block");
   c_reset_seq: cover property (@(posedge clk) $rose(resetN));
   c_protect: cover property (@(posedge clk) respValid && respFlag);
   c_suspend: cover property (@(posedge clk) stateReg == FS_WAIT);
   c_busy_seen: cover property (@(posedge clk) busyLateReg);
endmodule
`default_nettype wire

// ---- fsrsc_host_tb.sv ----
// Self-checking bench for the flash host controller.
`default_nettype none
module fsrsc_host_tb
   import fsrsc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] START_CMD = 8'h29;
   logic              clk, reset, reqValid, reqReady, reqErasing;
   logic              respValid, respFlag, chipSelN, writeEnN;
   logic              outputEnN, resetN, dataOe, ready_busy_out, gotFlag;
   fsrsc_op_type      reqOp;
   logic [ADDR_W-1:0] reqAddr, flashAddr, lastAddr, rdAddr;
   logic [7:0]        reqData, respData, dataOut, dataIn, lastData, gotData;
   int                lowNs, miscompares, total_checks, cyc, cycles;
   fsrsc_host fsrsc_host_inst (.clk(clk), .reset(reset),
      .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp),
      .reqAddr(reqAddr), .reqData(reqData), .reqErasing(reqErasing),
      .respValid(respValid), .respData(respData), .respFlag(respFlag),
      .chipSelN(chipSelN), .writeEnN(writeEnN), .outputEnN(outputEnN),
      .resetN(resetN), .flashAddr(flashAddr), .dataOut(dataOut),
      .dataOe(dataOe), .dataIn(dataIn), .ready_busy_out(ready_busy_out));
   fsrsc_flash_model fsrsc_flash_model_inst (.chipSelN(chipSelN),
      .writeEnN(writeEnN), .outputEnN(outputEnN), .resetN(resetN),
      .flashAddr(flashAddr), .dataOut(dataOut), .dataOe(dataOe),
      .dataIn(dataIn), .ready_busy_out(ready_busy_out),
      .lastAddr(lastAddr), .rdAddr(rdAddr), .lastData(lastData),
      .lowNs(lowNs));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // The answer pulse lasts one cycle, so it is caught on its own edge.
   always @(posedge clk) if (respValid === 1'b1) begin
      gotData <= respData;
      gotFlag <= respFlag;
   end
   // A hang is cut short well beyond the longest expected run.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         conclude();
      end
   end
   task automatic check(input logic [ADDR_W-1:0] got, exp, input string m);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task automatic checkMax(input int got, max, input string m);
      total_checks++;
      if (got > max) begin
         miscompares++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   // One request, held until taken; cyc counts cycles until ready again.
   task automatic issue(input fsrsc_op_type op,
                        input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(negedge clk);
      reqOp = op;
      reqAddr = a;
      reqData = d;
      reqValid = 1'b1;
      cyc = 0;
      while (reqReady !== 1'b1) @(negedge clk);
      @(negedge clk);
      reqValid = 1'b0;
      while (reqReady !== 1'b1) begin
         cyc++;
         @(negedge clk);
      end
      @(negedge clk);
   endtask
   task automatic t_program();
      issue(OP_WRITE, 20'h12345, START_CMD);
      // The device may take its whole busy delay after the strobe.
      repeat (BUSY_CYC) @(negedge clk);
      check(ready_busy_out, 1'b0, "busy after start");
      issue(OP_POLL, 20'h12345, 8'h00);
      check(rdAddr, 20'h12345, "poll address");
      check(gotFlag, 1'b1, "poll sees busy");
      issue(OP_SUSPEND, 20'h12345, 8'h00);
      checkMax(cyc, WRITE_CYC + SUSP_PGM_CYC + 2, "program suspend");
      check(lastData, CMD_SUSPEND, "suspend byte");
      check(ready_busy_out, 1'b1, "suspended");
      issue(OP_RESUME, 20'h12345, 8'h00);
      checkMax(cyc, WRITE_CYC + RESUME_CYC + 2, "program resume");
      check(lastData, CMD_RESUME, "resume byte");
      check(ready_busy_out, 1'b0, "busy again");
   endtask
   task automatic t_erase();
      reqErasing = 1'b1;
      issue(OP_WRITE, 20'h34000, START_CMD);
      issue(OP_WRITE, 20'h36000, START_CMD);
      check(lastAddr, 20'h36000, "second block");
      issue(OP_SUSPEND, 20'h36000, 8'h00);
      checkMax(cyc, WRITE_CYC + SUSP_ERS_CYC + 2, "erase suspend");
      issue(OP_POLL, 20'h36567, 8'h00);
      check((rdAddr & BLOCK_MASK) != 20'h36000, 1'b1, "poll outside");
      check(gotFlag, 1'b0, "ready in suspend");
      issue(OP_RESUME, 20'h36000, 8'h00);
      checkMax(cyc, WRITE_CYC + RESUME_CYC + 2, "erase resume");
      check(ready_busy_out, 1'b0, "erasing again");
      reqErasing = 1'b0;
   endtask
   task automatic t_protect();
      issue(OP_PROTCHK, 20'h50000, 8'h00);
      check(rdAddr & ID_SEL_MASK, ID_PROT_SEL, "id select");
      check(rdAddr & BLOCK_MASK, 20'h50000, "block select");
      check(gotData, PROT_MARK, "protect mark");
      check(gotFlag, 1'b1, "protected");
      issue(OP_PROTCHK, 20'h60000, 8'h00);
      check(gotFlag, 1'b0, "unprotected");
   endtask
   task automatic t_reset();
      issue(OP_RESET, 20'h00000, 8'h00);
      checkMax(RESET_LOW_NS, lowNs, "reset width");
      checkMax(cyc, RESET_LOW_CYC + READY_CYC + 8, "reset recovery");
      check(ready_busy_out, 1'b1, "read mode");
      check(resetN, 1'b1, "reset released");
   endtask
   task automatic conclude();
      if (miscompares == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      reset = 1'b1;
      reqValid = 1'b0;
      reqOp = OP_WRITE;
      reqAddr = '0;
      reqData = '0;
      reqErasing = 1'b0;
      miscompares = 0;
      total_checks = 0;
      cycles = 0;
      repeat (8) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      t_program();
      t_erase();
      t_protect();
      t_reset();
      conclude();
   end
endmodule
`default_nettype wire

// ---- fsrsc_pkg.sv ----
// Constants for the host-side flash command, suspend, reset and poll unit.
`default_nettype none
package fsrsc_pkg;
   localparam int CLK_MHZ = 50;
   localparam int RESET_LOW_NS = 500;
   localparam int RESET_LOW_CYC = (RESET_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int READY_US = 20;
   localparam int READY_CYC = READY_US * CLK_MHZ;
   localparam int SUSP_PGM_NS = 1500;
   localparam int SUSP_PGM_CYC = (SUSP_PGM_NS * CLK_MHZ + 999) / 1000;
   localparam int SUSP_ERS_US = 15;
   localparam int SUSP_ERS_CYC = SUSP_ERS_US * CLK_MHZ;
   localparam int RESUME_US = 1;
   localparam int RESUME_CYC = RESUME_US * CLK_MHZ;
   localparam int BUSY_NS = 90;
   localparam int BUSY_CYC = (BUSY_NS * CLK_MHZ + 999) / 1000;
   localparam int BUSY_SUSP_NS = 300;
   localparam int BUSY_SUSP_CYC = (BUSY_SUSP_NS * CLK_MHZ + 999) / 1000;
   localparam int WRITE_CYC = 4;
   localparam int CNT_W = 11;
   localparam int ADDR_W = 20;
   localparam logic [7:0] PROT_MARK = 8'h01;
   localparam logic [ADDR_W-1:0] ID_PROT_SEL = 20'h00002;
   localparam logic [ADDR_W-1:0] ID_SEL_MASK = 20'h00043;
   localparam logic [ADDR_W-1:0] BLOCK_MASK = 20'hff000;
   localparam logic [7:0] CMD_SUSPEND = 8'hb0;
   localparam logic [7:0] CMD_RESUME = 8'h30;
   typedef enum logic [2:0] {
      FS_IDLE  = 3'b000,
      FS_WRITE = 3'b001,
      FS_READ  = 3'b010,
      FS_WAIT  = 3'b011,
      FS_RESET = 3'b100,
      FS_RECOV = 3'b101
   } fsrsc_state_type;
   typedef enum logic [2:0] {
      OP_WRITE   = 3'b000,
      OP_READ    = 3'b001,
      OP_SUSPEND = 3'b010,
      OP_RESUME  = 3'b011,
      OP_PROTCHK = 3'b100,
      OP_RESET   = 3'b101,
      OP_POLL    = 3'b110
   } fsrsc_op_type;
endpackage
`default_nettype wire
